/* File: design/pbt_osc.sv */
// clock source of the timer: internal oscillator model or external clock
`timescale 1ns/1ps
`default_nettype none
module pbt_osc
	import pbt_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	input  wire logic ext_sel_i,
	input  wire logic ext_clk_i,
	output logic      tick_o
);
	import pbt_pkg::*;

	pbt_osc_s state;
	pbt_osc_s next_state;
	logic     osc_edge;
	logic     ext_edge;

	// ----------------------------------------
	// tick generation
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.ext_q = ext_clk_i;
		osc_edge = (state.div == PBT_OSC_LAST);
		ext_edge = ext_clk_i & ~state.ext_q;
		if (!run_i || ext_sel_i)
		begin
			next_state.div = '0;
		end
		else
		begin
			next_state.div = state.div + 4'h1;
		end
		tick_o = run_i & (ext_sel_i ? ext_edge : osc_edge);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

endmodule // pbt_osc
`default_nettype wire

/* File: design/pbt_pkg.sv */
// constants, types and register map of the programmable binary timer
// Notes on behaviour
// - sixteen stage binary counter divides clock source
// - counter advances once per source rising edge
// - selects 00 give stage 13, 01 stage 10
// - selects 11 stage 16; 10 bypasses eight stages
// - power-up reset only while power_up_init_off low
// - any reset clears all stages at once
// - master reset works whatever power_up_init_off says
// - oscillator stopped while any reset active
// - external clock replaces and bypasses the oscillator
// - output shows out_polarity while held in reset
// - out_polarity high inverts output outside reset
// - mode high: selected stage drives output continuously
// - mode low: done_latch sets once, output holds
// - manual reset or mode change clears done_latch
package pbt_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0]  PBT_ADDR_CTRL  = 4'h0;
	localparam logic [3:0]  PBT_ADDR_STAT  = 4'h4;
	localparam logic [3:0]  PBT_ADDR_COUNT = 4'h8;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int          PBT_CTRL_W     = 5;
	localparam int          PBT_F_SEL_LO   = 0;
	localparam int          PBT_F_SEL_HI   = 1;
	localparam int          PBT_F_MODE     = 2;
	localparam int          PBT_F_POL      = 3;
	localparam int          PBT_F_EXT_SEL  = 4;
	localparam logic [4:0]  PBT_CTRL_RST   = 5'h04;

	// ----------------------------------------
	// status fields
	// ----------------------------------------
	localparam int          PBT_S_DONE     = 0;
	localparam int          PBT_S_OUT      = 1;
	localparam int          PBT_S_RESET    = 2;

	// ----------------------------------------
	// counter and stage selection
	// ----------------------------------------
	localparam int          PBT_CNT_W      = 16;
	localparam int          PBT_BYPASS_LSB = 8;
	localparam int          PBT_STAGE_00   = 13;
	localparam int          PBT_STAGE_01   = 10;
	localparam int          PBT_STAGE_10   = 16;
	localparam int          PBT_STAGE_11   = 16;

	// ----------------------------------------
	// internal oscillator model and state types
	// ----------------------------------------
	localparam int          PBT_DIV_W      = 4;
	localparam logic [3:0]  PBT_OSC_LAST   = 4'hf;

	typedef enum logic [1:0] {
		PBT_POR_ARM  = 2'b01,
		PBT_POR_IDLE = 2'b10
	} pbt_por_e;

	typedef struct packed {
		logic [PBT_CTRL_W-1:0] ctrl;
		logic [PBT_CNT_W-1:0]  cnt;
		logic                  done;
		logic                  tout;
		logic                  mode_q;
		pbt_por_e              por;
		logic                  ack;
		logic [31:0]           dat;
	} pbt_state_s;

	typedef struct packed {
		logic [PBT_DIV_W-1:0]  div;
		logic                  ext_q;
	} pbt_osc_s;

endpackage

/* File: design/pbt_timer.sv */
// top of the programmable binary timer with its wishbone register slave
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pbt_timer
	import pbt_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        manual_reset_in_i,
	input  wire logic        power_up_init_off_i,
	input  wire logic        ext_clk_i,
	output logic             timer_out_o,
	output logic             done_latch_o
);
	import pbt_pkg::*;

	pbt_state_s state;
	pbt_state_s next_state;

	logic       tick;
	logic       por_pulse;
	logic       auto_rst;
	logic       reset_active;
	logic       sel_lo;
	logic       sel_hi;
	logic       mode;
	logic       pol;
	logic       ext_sel;
	logic       bypass;
	logic       stage_q;
	logic       mode_flip;
	logic       req;
	logic       wr_now;

	// ----------------------------------------
	// control decode
	// ----------------------------------------
	assign sel_lo  = state.ctrl[PBT_F_SEL_LO];
	assign sel_hi  = state.ctrl[PBT_F_SEL_HI];
	assign mode    = state.ctrl[PBT_F_MODE];
	assign pol     = state.ctrl[PBT_F_POL];
	assign ext_sel = state.ctrl[PBT_F_EXT_SEL];
	assign bypass  = sel_hi & ~sel_lo;

	// ----------------------------------------
	// reset sources
	// ----------------------------------------
	// one pulse after power-on
	assign por_pulse = (state.por == PBT_POR_ARM);
	assign auto_rst = por_pulse & ~power_up_init_off_i;
	assign reset_active = auto_rst | manual_reset_in_i;
	assign mode_flip = (mode != state.mode_q);

	// ----------------------------------------
	// clock source
	// ----------------------------------------
	// oscillator held off whenever a reset is active
	pbt_osc u_osc (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (~reset_active),
		.ext_sel_i (ext_sel),
		.ext_clk_i (ext_clk_i),
		.tick_o    (tick)
	);

	// ----------------------------------------
	// stage selection
	// ----------------------------------------
	always_comb
	begin
		// stage 13 for select 00, stage 10 for 01, stage 16 for both 10 and 11
		case ({sel_hi, sel_lo})
			2'b00:   stage_q = state.cnt[PBT_STAGE_00-1];
			2'b01:   stage_q = state.cnt[PBT_STAGE_01-1];
			2'b10:   stage_q = state.cnt[PBT_STAGE_10-1];
			2'b11:   stage_q = state.cnt[PBT_STAGE_11-1];
			default: stage_q = 1'b0;
		endcase
	end

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	assign req    = wb_cyc_i & wb_stb_i;
	assign wr_now = req & wb_we_i & state.ack;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.mode_q = mode;

		// power-up sequencing
		case (state.por)
			PBT_POR_ARM:  next_state.por = PBT_POR_IDLE;
			PBT_POR_IDLE: next_state.por = PBT_POR_IDLE;
			default:      next_state.por = PBT_POR_IDLE;
		endcase

		if (reset_active)
		begin
			next_state.cnt = '0;
		end
		else if (tick)
		begin
			if (bypass)
			begin
				next_state.cnt[PBT_CNT_W-1:PBT_BYPASS_LSB] =
					state.cnt[PBT_CNT_W-1:PBT_BYPASS_LSB] + 8'h01;
				next_state.cnt[PBT_BYPASS_LSB-1:0] = '0;
			end
			else
			begin
				next_state.cnt = state.cnt + 16'h0001;
			end
		end

		// restart on reset or mode change
		if (reset_active || mode_flip)
		begin
			next_state.done = 1'b0;
		end
		// latch on first high of stage
		else if (!mode && stage_q)
		begin
			next_state.done = 1'b1;
		end

		if (reset_active)
		begin
			next_state.tout = pol;
		end
		else if (mode)
		begin
			next_state.tout = stage_q ^ pol;
		end
		else
		begin
			next_state.tout = state.done ^ pol;
		end

		// single-cycle wishbone: ack one cycle after request, then drop
		next_state.ack = req & ~state.ack;
		next_state.dat = '0;
		if (req && !state.ack && !wb_we_i)
		begin
			case (wb_adr_i)
				PBT_ADDR_CTRL:  next_state.dat[PBT_CTRL_W-1:0] = state.ctrl;
				PBT_ADDR_STAT:
				begin
					next_state.dat[PBT_S_DONE]  = state.done;
					next_state.dat[PBT_S_OUT]   = state.tout;
					next_state.dat[PBT_S_RESET] = reset_active;
				end
				PBT_ADDR_COUNT: next_state.dat[PBT_CNT_W-1:0] = state.cnt;
				default:        next_state.dat = '0;
			endcase
		end
		// write lands at the edge where ack is sampled
		if (wr_now && wb_adr_i == PBT_ADDR_CTRL && wb_sel_i[0])
		begin
			next_state.ctrl = wb_dat_i[PBT_CTRL_W-1:0];
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state.ctrl   <= PBT_CTRL_RST;
			state.cnt    <= '0;
			state.done   <= 1'b0;
			state.tout   <= 1'b0;
			state.mode_q <= PBT_CTRL_RST[PBT_F_MODE];
			state.por    <= PBT_POR_ARM;
			state.ack    <= 1'b0;
			state.dat    <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign wb_ack_o     = state.ack;
	assign wb_dat_o     = state.dat;
	assign timer_out_o  = state.tout;
	assign done_latch_o = state.done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_reset_clears_cnt: assert property (
		@(posedge clk_i) disable iff (rst_i)
		reset_active |=> (state.cnt == '0))
	else $error("counter not cleared by reset");

	a_osc_halted: assert property (
		@(posedge clk_i) disable iff (rst_i)
		reset_active |-> !tick)
	else $error("count tick during reset");

	a_out_reset_level: assert property (
		@(posedge clk_i) disable iff (rst_i)
		reset_active ##1 reset_active |-> (timer_out_o == $past(pol)))
	else $error("output not at polarity level in reset");

	a_count_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!reset_active && tick && !bypass)
			|=> (state.cnt == $past(state.cnt) + 16'h0001))
	else $error("counter did not advance by one");

	a_bypass_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!reset_active && tick && bypass)
			|=> (state.cnt[15:8] == $past(state.cnt[15:8]) + 8'h01)
			&& (state.cnt[7:0] == 8'h00))
	else $error("bypass count wrong");

	a_hold_no_tick: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!reset_active && !tick) |=> $stable(state.cnt))
	else $error("counter moved without a tick");

	a_done_sticks: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(state.done && !reset_active && !mode_flip) |=> state.done)
	else $error("done latch lost without restart");

	a_done_sets: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!mode && !mode_flip && !reset_active && stage_q)
			|=> state.done ##1 ($past(reset_active) || $past(mode)
			|| (timer_out_o == !$past(pol))))
	else $error("single cycle did not latch");

	a_restart_clears: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(mode_flip || manual_reset_in_i) |=> !state.done)
	else $error("restart did not clear done latch");

	a_init_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(por_pulse && power_up_init_off_i && !manual_reset_in_i)
			|-> !reset_active)
	else $error("power-up reset not inhibited");

	a_recirc_out: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(mode && !mode_flip && !reset_active && !wr_now)
			|=> (timer_out_o == ($past(stage_q) ^ $past(pol))))
	else $error("divider output wrong");

	a_por_once: assert property (
		@(posedge clk_i) disable iff (rst_i)
		por_pulse |=> !por_pulse [*4])
	else $error("power-up pulse repeated");

	a_wb_ack: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
	else $error("bus answer not one cycle");

	a_stage_thirteen: assert property (
		@(posedge clk_i) disable iff (rst_i)
		({sel_hi, sel_lo} == 2'b00) |-> (stage_q == state.cnt[12]))
	else $error("stage 13 not routed to output");

	a_stage_ten: assert property (
		@(posedge clk_i) disable iff (rst_i)
		({sel_hi, sel_lo} == 2'b01) |-> (stage_q == state.cnt[9]))
	else $error("stage 10 not routed to output");

	a_stage_sixteen: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sel_hi |-> (stage_q == state.cnt[15]))
	else $error("stage 16 not routed to output");

	a_init_active: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(por_pulse && !power_up_init_off_i) |-> reset_active)
	else $error("power-up reset missing");

	a_master_any: assert property (
		@(posedge clk_i) disable iff (rst_i)
		manual_reset_in_i |-> reset_active)
	else $error("master reset not applied");

	a_ext_tick: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ext_sel && !reset_active)
			|-> (tick == (ext_clk_i && !$past(ext_clk_i))))
	else $error("external edge not counted once");

	a_osc_period: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!ext_sel && !reset_active && tick)
			|=> (!tick || ext_sel))
	else $error("oscillator ticks back to back");

	a_single_out: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!reset_active && !mode)
			|=> (timer_out_o == ($past(state.done) ^ $past(pol))))
	else $error("single cycle output wrong");

	a_pol_invert: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!reset_active && mode && pol)
			|=> (timer_out_o == !$past(stage_q)))
	else $error("inverted output sense wrong");

	a_dat_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> (wb_dat_o == 32'h0))
	else $error("read data outside answer");

	a_ctrl_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(wr_now && (wb_adr_i == PBT_ADDR_CTRL) && wb_sel_i[0])
			|=> (state.ctrl == $past(wb_dat_i[4:0])))
	else $error("control write lost");

endmodule // pbt_timer
`default_nettype wire

/* File: tb/pbt_sys_model.sv */
// far-side system logic model: bursts of external clock edges
`timescale 1ns/1ps
`default_nettype none
module pbt_sys_model
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire logic [15:0] count_i,
	input  wire logic        slow_i,
	output logic             ext_clk_o,
	output logic             busy_o
);
	logic [15:0] rem;
	logic [1:0]  gap;

	// ----------------------------------------
	// edge burst
	// ----------------------------------------
	// external clock supplied
	// clock rests low between bursts, never free running
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_clk_o <= 1'b0;
			rem       <= 16'h0;
			gap       <= 2'h0;
		end
		else if (start_i && rem == 16'h0)
			rem <= count_i;
		else if (rem != 16'h0 || ext_clk_o)
		begin
			if (gap != 2'h0)
				gap <= gap - 2'h1;
			else
			begin
				gap <= slow_i ? 2'h3 : 2'h0;
				if (ext_clk_o)
					ext_clk_o <= 1'b0;
				else
				begin
					ext_clk_o <= 1'b1;
					rem       <= rem - 16'h1;
				end
			end
		end
	end

	assign busy_o = (rem != 16'h0) | ext_clk_o;
endmodule // pbt_sys_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the programmable binary timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pbt_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, mr, aroff, start, slow;
	logic        ack, ext_clk, busy, tout, done;
	logic [3:0]  adr;
	logic [15:0] npls;
	logic [31:0] wdat, rdat, rd_o;
	int          bad_count, n_tests, cyc_n;

	pbt_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd_o),
		.wb_ack_o(ack), .manual_reset_in_i(mr), .power_up_init_off_i(aroff),
		.ext_clk_i(ext_clk), .timer_out_o(tout), .done_latch_o(done));
	pbt_sys_model sys_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .count_i(npls),
		.slow_i(slow), .ext_clk_o(ext_clk), .busy_o(busy));

	// ----------------------------------------
	// clock, timeout, tasks
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// tests need about 16k cycles
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n > 60000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until the edge that samples ack; only the bench timeout ends a hang
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		rdat = rd_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	// settle window covers tick, done and output stages
	task automatic pulses(input logic [15:0] n, input logic s);
		@(posedge clk_i);
		npls  <= n;
		slow  <= s;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		@(negedge clk_i);
		while (busy === 1'b1)
			@(negedge clk_i);
		repeat (5) @(negedge clk_i);
	endtask

	task automatic mrst();
		@(posedge clk_i);
		mr <= 1'b1;
		repeat (2) @(posedge clk_i);
		mr <= 1'b0;
		repeat (3) @(negedge clk_i);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{rst_i, cyc, stb, we, mr, aroff, start, slow} = 8'h80;
		{adr, npls, wdat} = '0;
		{bad_count, n_tests, cyc_n} = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, 4'hc, 32'hff);
		wb(1'b1, PBT_ADDR_COUNT, 32'h1234);
		wb(1'b0, PBT_ADDR_COUNT, 32'h0);
		check(rdat, 32'h0);
		wb(1'b0, 4'hc, 32'h0);
		check(rdat, 32'h0);
		wb(1'b0, PBT_ADDR_CTRL, 32'h0);
		check(rdat, 32'(PBT_CTRL_RST));
		check(32'(tout), 32'h0);
		check(32'(done), 32'h0);
		wb(1'b1, PBT_ADDR_CTRL, 32'h15);
		// internal oscillator may have ticked before the switch
		mrst();
		pulses(16'd511, 1'b0);
		wb(1'b0, PBT_ADDR_COUNT, 32'h0);
		check(rdat, 32'h1ff);
		check(32'(tout), 32'h0);
		pulses(16'd1, 1'b0);
		check(32'(tout), 32'h1);
		wb(1'b1, PBT_ADDR_CTRL, 32'h1d);
		repeat (3) @(negedge clk_i);
		check(32'(tout), 32'h0);
		@(posedge clk_i);
		aroff <= 1'b1;
		mr    <= 1'b1;
		pulses(16'd5, 1'b0);
		wb(1'b0, PBT_ADDR_COUNT, 32'h0);
		check(rdat, 32'h0);
		check(32'(tout), 32'h1);
		wb(1'b0, PBT_ADDR_STAT, 32'h0);
		check(rdat, 32'h6);
		@(posedge clk_i);
		mr    <= 1'b0;
		aroff <= 1'b0;
		wb(1'b1, PBT_ADDR_CTRL, 32'h11);
		pulses(16'd512, 1'b1);
		check(32'({done, tout}), 32'h3);
		pulses(16'd512, 1'b0);
		check(32'({done, tout}), 32'h3);
		wb(1'b1, PBT_ADDR_CTRL, 32'h15);
		repeat (3) @(negedge clk_i);
		check(32'({done, tout}), 32'h0);
		wb(1'b1, PBT_ADDR_CTRL, 32'h11);
		pulses(16'd512, 1'b0);
		check(32'(done), 32'h1);
		mrst();
		check(32'(done), 32'h0);
		wb(1'b1, PBT_ADDR_CTRL, 32'h16);
		pulses(16'd3, 1'b0);
		wb(1'b0, PBT_ADDR_COUNT, 32'h0);
		check(rdat, 32'h300);
		pulses(16'd125, 1'b0);
		check(32'(tout), 32'h1);
		wb(1'b1, PBT_ADDR_CTRL, 32'h17);
		repeat (3) @(negedge clk_i);
		check(32'(tout), 32'h1);
		mrst();
		wb(1'b1, PBT_ADDR_CTRL, 32'h14);
		pulses(16'd4095, 1'b0);
		check(32'(tout), 32'h0);
		pulses(16'd1, 1'b0);
		check(32'(tout), 32'h1);
		wb(1'b0, PBT_ADDR_COUNT, 32'h0);
		check(rdat, 32'h1000);
		mrst();
		wb(1'b1, PBT_ADDR_CTRL, 32'h04);
		repeat (160) @(posedge clk_i);
		wb(1'b0, PBT_ADDR_COUNT, 32'h0);
		check(32'(rdat >= 32'd8 && rdat <= 32'd13), 32'h1);
		// second reset with the power-up pulse inhibited: the oscillator
		// starts one cycle earlier, so the count is already 1 here
		@(posedge clk_i);
		rst_i <= 1'b1;
		aroff <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (15) @(posedge clk_i);
		wb(1'b0, PBT_ADDR_COUNT, 32'h0);
		check(rdat, 32'h1);
		check(32'({done, tout}), 32'h0);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
